/* adc_input_routing_regs.sv */
// AHB-Lite register bank that steers the ADC input routing switches
//
// Contract
// - microphone_input positive route code at D7-D6
// - auxiliary_input_one positive route code at D5-D4
// - auxiliary_input_two positive route code at D3-D2
// - common_mode_reference negative route code at D7-D6
// - auxiliary_input_two negative route code at D5-D4
// - D7 ties idle microphone_input to common mode
// - D6 ties idle auxiliary_input_one to common mode
// - D5 ties idle auxiliary_input_two to common mode
// - D0 reads one once gains applied
// - location 0 is eight-bit page selector
//
// The AHB-Lite interface to the registers was decided locally.
`timescale 1ns/1ps
`default_nettype none
module adc_input_routing_regs
  import adc_routing_pkg::*;
#(
  parameter int SETTLE_CYCLES = SETTLE_CYC // Gain settling count
) (
  input  wire logic        clk,
  input  wire logic        rst,
  // AHB-Lite slave
  input  wire logic        hsel,
  input  wire logic [31:0] haddr,
  input  wire logic [1:0]  htrans,
  input  wire logic        hwrite,
  input  wire logic [2:0]  hsize,
  input  wire logic [31:0] hwdata,
  input  wire logic        hready,
  output logic             hreadyout,
  output logic [31:0]      hrdata,
  output logic             hresp,
  // Analog bypass usage, same clock domain
  input  wire logic        byp_mic,
  input  wire logic        byp_auxiliary_input_one,
  // Analog switch controls and current page
  output route_ctl_t       ctl,
  output logic [7:0]       page
);

  ////////////////////////////////////////////////////////////
  // State

  // All state of the block in one record
  typedef struct packed {
    logic [7:0]  page;  // Page selector
    logic [7:0]  pos;   // Positive terminal select
    logic [7:0]  neg;   // Negative terminal select
    logic [2:0]  term;  // Termination bits D7-D5
    logic [15:0] cnt;   // Settling countdown
    logic        done;  // Gains applied
    logic        wr;    // Write data phase pending
    logic [7:0]  widx;  // Location of that write
    logic [31:0] rdata; // Read data for the bus
    logic        rdy;   // Ready toward the bus
    route_ctl_t  ctl;   // Registered switch controls
  } regs_state_t;

  // Counter start value at its own width
  localparam logic [15:0] CNT_LOAD = 16'(SETTLE_CYCLES);

  // Value after reset: the counter runs so that gains settle
  localparam regs_state_t ST_RST = '{
    page:  RST_BYTE,
    pos:   RST_BYTE,
    neg:   RST_BYTE,
    term:  3'h0,
    cnt:   CNT_LOAD,
    done:  1'b0,
    wr:    1'b0,
    widx:  8'h00,
    rdata: 32'h0000_0000,
    rdy:   1'b1,
    ctl:   '0
  };

  regs_state_t s_r;   // Current state
  regs_state_t s_nxt; // Next state

  ////////////////////////////////////////////////////////////
  // Bus decode

  // A transfer is taken when selected, active and bus ready
  logic       take;
  logic [7:0] aidx; // Location addressed
  assign take = hsel && hready && htrans[1];
  assign aidx = haddr[9:2];

  // Read mux over the stored state
  function automatic logic [7:0] rd_byte(
    input regs_state_t st,
    input logic [7:0]  idx
  );
    logic [7:0] v;
    v = 8'h00;
    if (idx == IDX_PAGE) begin
      // Page selector answers on every page
      v = st.page;
    end else if (st.page == PG_ANALOG) begin
      case (idx)
        IDX_POS: v = st.pos;
        IDX_NEG: v = st.neg;
        // Status bit sits under the termination bits
        IDX_TERM: v = {st.term, 4'h0, st.done};
        default: v = 8'h00;
      endcase
    end
    return v;
  endfunction

  ////////////////////////////////////////////////////////////
  // Next state

  // Write data phase, settling, address phase, switch drive
  always_comb begin
    s_nxt = s_r;
    s_nxt.wr = 1'b0;
    s_nxt.rdy = 1'b1;

    // Settling countdown
    if (s_r.cnt != 16'h0000) begin
      s_nxt.cnt = s_r.cnt - 16'h0001;
    end

    // Data phase of a write: hwdata stands now
    if (s_r.wr) begin
      if (s_r.widx == IDX_PAGE) begin
        // Any of 256 pages may be chosen
        s_nxt.page = hwdata[7:0];
      end else if (s_r.page == PG_ANALOG) begin
        case (s_r.widx)
          IDX_POS: begin
            // Reserved bits masked off
            s_nxt.pos = hwdata[7:0] & POS_WMASK;
          end
          IDX_NEG: begin
            s_nxt.neg = hwdata[7:0] & NEG_WMASK;
          end
          IDX_TERM: begin
            // D0 is read only; writes to it are dropped
            s_nxt.term = hwdata[7:5];
          end
          default: begin
            // Reserved locations keep nothing
          end
        endcase
      end
    end

    // A change of routing changes PGA gain: restart settling
    if ((s_nxt.pos != s_r.pos) || (s_nxt.neg != s_r.neg)) begin
      s_nxt.cnt = CNT_LOAD;
    end
    s_nxt.done = (s_nxt.cnt == 16'h0000);

    // Address phase
    if (take) begin
      if (hwrite) begin
        s_nxt.wr = 1'b1;
        s_nxt.widx = aidx;
      end else begin
        // Read data is prepared for the following data phase
        s_nxt.rdata = {24'h00_0000, rd_byte(s_r, aidx)};
      end
    end

    // Switch controls straight from the stored fields
    s_nxt.ctl.mic_p  = s_nxt.pos[F_HI_LSB +: 2];
    s_nxt.ctl.auxiliary_input_one_p = s_nxt.pos[F_MID_LSB +: 2];
    s_nxt.ctl.auxiliary_input_two_p = s_nxt.pos[F_LO_LSB +: 2];
    s_nxt.ctl.cm_n   = s_nxt.neg[F_HI_LSB +: 2];
    s_nxt.ctl.auxiliary_input_two_n = s_nxt.neg[F_MID_LSB +: 2];

    // Idle inputs: tie to common mode only when unused
    s_nxt.ctl.mic_cm = s_nxt.term[T_MIC_BIT - 5]
      && (s_nxt.ctl.mic_p == RT_OFF)
      && !byp_mic;
    s_nxt.ctl.auxiliary_input_one_cm = s_nxt.term[T_AX1_BIT - 5]
      && (s_nxt.ctl.auxiliary_input_one_p == RT_OFF)
      && !byp_auxiliary_input_one;
    // Second auxiliary input has no bypass path
    s_nxt.ctl.auxiliary_input_two_cm = s_nxt.term[T_AX2_BIT - 5]
      && (s_nxt.ctl.auxiliary_input_two_p == RT_OFF)
      && (s_nxt.ctl.auxiliary_input_two_n == RT_OFF);
  end

  ////////////////////////////////////////////////////////////
  // Registers

  // Synchronous reset of the whole record
  always_ff @(posedge clk) begin
    if (rst) begin
      s_r <= ST_RST;
    end else begin
      s_r <= s_nxt;
    end
  end

  // Outputs from flip-flops; hresp is tied to OKAY
  assign hreadyout = s_r.rdy;
  assign hrdata    = s_r.rdata;
  assign hresp     = 1'b0;
  assign ctl       = s_r.ctl;
  assign page      = s_r.page;

  ////////////////////////////////////////////////////////////
  // Assertions

  default clocking cb @(posedge clk);
  endclocking
  default disable iff (rst);

  // Write data phases on the analog page
  sequence s_pos_wr;
    s_r.wr && (s_r.widx == IDX_POS) && (s_r.page == PG_ANALOG);
  endsequence
  sequence s_neg_wr;
    s_r.wr && (s_r.widx == IDX_NEG) && (s_r.page == PG_ANALOG);
  endsequence
  sequence s_gain_wr;
    (s_pos_wr and (s_r.pos != (hwdata[7:0] & POS_WMASK)))
    or (s_neg_wr and (s_r.neg != (hwdata[7:0] & NEG_WMASK)));
  endsequence

  property p_mic_route;
    s_pos_wr |=> ctl.mic_p == $past(hwdata[7:6]);
  endproperty
  a_mic_route: assert property (p_mic_route)
    else $error("microphone route not from D7-D6");

  property p_auxiliary_input_one_route;
    s_pos_wr |=> ctl.auxiliary_input_one_p == $past(hwdata[5:4]);
  endproperty
  a_auxiliary_input_one_route: assert property (p_auxiliary_input_one_route)
    else $error("aux one route not from D5-D4");

  property p_auxiliary_input_two_route;
    s_pos_wr |=> ctl.auxiliary_input_two_p == $past(hwdata[3:2]);
  endproperty
  a_auxiliary_input_two_route: assert property (p_auxiliary_input_two_route)
    else $error("aux two route not from D3-D2");

  property p_cm_route;
    s_neg_wr |=> ctl.cm_n == $past(hwdata[7:6]);
  endproperty
  a_cm_route: assert property (p_cm_route)
    else $error("common mode route not from D7-D6");

  property p_aux2n_route;
    s_neg_wr |=> ctl.auxiliary_input_two_n == $past(hwdata[5:4]);
  endproperty
  a_aux2n_route: assert property (p_aux2n_route)
    else $error("negative aux two route not from D5-D4");

  property p_mic_tie;
    ctl.mic_cm |-> (ctl.mic_p == RT_OFF) && !$past(byp_mic);
  endproperty
  a_mic_tie: assert property (p_mic_tie)
    else $error("microphone tied while in use");

  property p_auxiliary_input_one_tie;
    ctl.auxiliary_input_one_cm |-> (ctl.auxiliary_input_one_p == RT_OFF) && !$past(byp_auxiliary_input_one);
  endproperty
  a_auxiliary_input_one_tie: assert property (p_auxiliary_input_one_tie)
    else $error("aux one tied while in use");

  property p_auxiliary_input_two_tie;
    ctl.auxiliary_input_two_cm |-> (ctl.auxiliary_input_two_p == RT_OFF) && (ctl.auxiliary_input_two_n == RT_OFF);
  endproperty
  a_auxiliary_input_two_tie: assert property (p_auxiliary_input_two_tie)
    else $error("aux two tied while in use");

  property p_settle;
    s_gain_wr |=> !s_r.done [*8];
  endproperty
  a_settle: assert property (p_settle)
    else $error("gains flagged applied too early");

  property p_page_read;
    take && !hwrite && (aidx == IDX_PAGE)
      |=> hrdata == {24'h00_0000, $past(s_r.page)};
  endproperty
  a_page_read: assert property (p_page_read)
    else $error("page selector read wrong");

  property p_ctl_on_write;
    $changed(ctl.cm_n) |-> $past(s_r.wr);
  endproperty
  a_ctl_on_write: assert property (p_ctl_on_write)
    else $error("switch control moved without a write");

  // Gains may only be flagged applied once the countdown has run out
  property p_done_rise;
    $rose(s_r.done) |-> ($past(s_r.cnt) == 16'h0001);
  endproperty
  a_done_rise: assert property (p_done_rise)
    else $error("gains flagged applied before settling ended");

endmodule
`default_nettype wire

/* adc_routing_pkg.sv */
// Constants and types for the ADC input routing register bank
`default_nettype none
package adc_routing_pkg;
  // Register locations (indices); byte address is four times these
  localparam logic [7:0] IDX_PAGE  = 8'h00; // Page selector, every page
  localparam logic [7:0] IDX_TRSV  = 8'h01; // Touch page reserved
  localparam logic [7:0] IDX_POS   = 8'h30; // Positive terminal select
  localparam logic [7:0] IDX_NEG   = 8'h31; // Negative terminal select
  localparam logic [7:0] IDX_TERM  = 8'h32; // Termination and status
  // Pages that hold registers of this block
  localparam logic [7:0] PG_ANALOG = 8'h01;
  localparam logic [7:0] PG_TOUCH  = 8'h03;
  // Field positions
  localparam int F_HI_LSB  = 6; // D7-D6
  localparam int F_MID_LSB = 4; // D5-D4
  localparam int F_LO_LSB  = 2; // D3-D2
  localparam int T_MIC_BIT = 7; // D7
  localparam int T_AX1_BIT = 6; // D6
  localparam int T_AX2_BIT = 5; // D5
  localparam int T_DONE    = 0; // D0, read only
  // Writable bits; reserved bits always read zero
  localparam logic [7:0] POS_WMASK = 8'hFC;
  localparam logic [7:0] NEG_WMASK = 8'hF0;
  localparam logic [7:0] TRM_WMASK = 8'hE0;
  // Reset values
  localparam logic [7:0] RST_BYTE  = 8'h00;
  // Route code meaning not routed
  localparam logic [1:0] RT_OFF    = 2'h0;
  // Gain settling time after a routing change
  localparam int CLK_MHZ   = 100;
  localparam int SETTLE_NS = 1000;
  localparam int SETTLE_CYC = (SETTLE_NS * CLK_MHZ + 999) / 1000;
  // Analog switch controls
  typedef struct packed {
    logic [1:0] mic_p;   // microphone_input to positive terminal
    logic [1:0] auxiliary_input_one_p;  // auxiliary_input_one to positive terminal
    logic [1:0] auxiliary_input_two_p;  // auxiliary_input_two to positive terminal
    logic [1:0] cm_n;    // common_mode_reference to negative terminal
    logic [1:0] auxiliary_input_two_n;  // auxiliary_input_two to negative terminal
    logic       mic_cm;  // Tie microphone_input to common mode
    logic       auxiliary_input_one_cm; // Tie auxiliary_input_one to common mode
    logic       auxiliary_input_two_cm; // Tie auxiliary_input_two to common mode
  } route_ctl_t;
endpackage
`default_nettype wire

/* adc_input_routing_regs_tb.sv */
// Self-checking testbench for the ADC input routing register bank
`timescale 1ns/1ps
`default_nettype none
module adc_input_routing_regs_tb;
  import adc_routing_pkg::*;
  localparam int SC = 10;           // Short settling count keeps the run brief
  logic        clk = 1'b0;          // 100 MHz clock
  logic        rst = 1'b1;          // Synchronous reset, high
  logic        hsel = 1'b0;         // Slave select
  logic        hwrite = 1'b0;       // Transfer direction
  logic        byp_mic = 1'b0;      // Bypass uses microphone_input
  logic        byp_auxiliary_input_one = 1'b0;     // Bypass uses auxiliary_input_one
  logic [1:0]  htrans = 2'h0;       // Transfer type
  logic [2:0]  hsize = 3'h2;        // Word transfers only
  logic [31:0] haddr = 32'h0000_0000;
  logic [31:0] hwdata = 32'h0000_0000;
  logic [31:0] hrdata;              // Read data from the slave
  logic [31:0] rd;                  // Last read data taken
  logic        hreadyout;           // Slave ready, fed back as hready
  logic        hresp;               // Always OKAY
  route_ctl_t  ctl;                 // Switch controls
  logic [7:0]  page;                // Current page
  logic [7:0]  p, n, t;             // Register values last written
  int          err_count = 0;
  int          total_checks = 0;
  int          cyc = 0;             // Cycle count for the hang guard

  always #5 clk = ~clk;

  adc_input_routing_regs #(.SETTLE_CYCLES(SC)) u_adc_input_routing_regs (
    .clk(clk), .rst(rst), .hsel(hsel), .haddr(haddr), .htrans(htrans), .hwrite(hwrite),
    .hsize(hsize), .hwdata(hwdata), .hready(hreadyout), .hreadyout(hreadyout),
    .hrdata(hrdata), .hresp(hresp), .byp_mic(byp_mic), .byp_auxiliary_input_one(byp_auxiliary_input_one),
    .ctl(ctl), .page(page));

  ////////////////////////////////////////////////////////////////////////////
  // Verdict in one place, reached by the main sequence or the hang guard
  task automatic conclude;
    if (err_count == 0 && total_checks > 0) begin
      $display("STATUS OK");
    end else begin
      $display("STATUS NOT OK");
    end
    $finish;
  endtask

  // Whole run needs a few hundred cycles; far above that means a hang
  always @(posedge clk) begin
    cyc <= cyc + 1;
    if (cyc == 20000) begin
      err_count++;
      conclude();
    end
  end

  // Compare of bus and page values
  task automatic chk_val(input string nm, input logic [31:0] e, input logic [31:0] g);
    total_checks++;
    if (g !== e) begin
      err_count++;
      $display("Error %s expected %h seen %h", nm, e, g);
    end
  endtask

  // Compare of the switch control bundle
  task automatic chk_ctl(input route_ctl_t e, input route_ctl_t g);
    total_checks++;
    if (g !== e) begin
      err_count++;
      $display("Error ctl expected %h seen %h", e, g);
    end
  endtask

  ////////////////////////////////////////////////////////////////////////////
  // One single AHB-Lite transfer; address held until hready is seen high
  task automatic xfer(input logic wr, input logic [7:0] loc, input logic [7:0] wd);
    hsel   <= 1'b1;
    htrans <= 2'h2;
    hwrite <= wr;
    haddr  <= {22'h0, loc, 2'h0};
    @(posedge clk);
    while (hreadyout !== 1'b1) @(posedge clk);
    hsel   <= 1'b0;
    htrans <= 2'h0;
    hwdata <= {24'h0, wd};
    @(posedge clk);
    while (hreadyout !== 1'b1) @(posedge clk);
    rd = hrdata;
  endtask

  task automatic rd_chk(input string nm, input logic [7:0] loc, input logic [7:0] e);
    xfer(1'b0, loc, 8'h00);
    chk_val(nm, {24'h0, e}, rd);
    // Slave never stalls and always answers OKAY
    chk_val("hreadyout", 32'h0000_0001, {31'h0, hreadyout});
    chk_val("hresp", 32'h0000_0000, {31'h0, hresp});
  endtask

  // Switch controls the rules call for; idle inputs only are tied
  function automatic route_ctl_t exp_ctl(input logic [7:0] pv, nv, tv, input logic bm, ba);
    route_ctl_t c;
    c.mic_p   = pv[7:6];
    c.auxiliary_input_one_p  = pv[5:4];
    c.auxiliary_input_two_p  = pv[3:2];
    c.cm_n    = nv[7:6];
    c.auxiliary_input_two_n  = nv[5:4];
    c.mic_cm  = tv[7] && pv[7:6] == 2'h0 && !bm;
    c.auxiliary_input_one_cm = tv[6] && pv[5:4] == 2'h0 && !ba;
    c.auxiliary_input_two_cm = tv[5] && pv[3:2] == 2'h0 && nv[5:4] == 2'h0;
    return c;
  endfunction

  // Program all three routing registers, then check outputs and read-back
  task automatic setreg(input logic [7:0] pv, nv, tv);
    p = pv;
    n = nv;
    t = tv;
    xfer(1'b1, IDX_POS, p);
    xfer(1'b1, IDX_NEG, n);
    xfer(1'b1, IDX_TERM, t);
    repeat (2) @(posedge clk);
    chk_ctl(exp_ctl(p, n, t, byp_mic, byp_auxiliary_input_one), ctl);
    rd_chk("pos", IDX_POS, p & POS_WMASK);
    rd_chk("neg", IDX_NEG, n & NEG_WMASK);
    xfer(1'b0, IDX_TERM, 8'h00);
    chk_val("term", {25'h0, t[7:1]}, {25'h0, rd[7:1]});
  endtask

  ////////////////////////////////////////////////////////////////////////////
  // Main sequence
  initial begin
    p = 8'($urandom(80));
    repeat (2) @(posedge clk);
    rst <= 1'b0;
    @(posedge clk);
    chk_ctl(route_ctl_t'(0), ctl);
    chk_val("page", 32'h0000_0000, {24'h0, page});
    rd_chk("page_rd", IDX_PAGE, 8'h00);
    rd_chk("pos_pg0", IDX_POS, 8'h00);
    xfer(1'b1, IDX_PAGE, PG_ANALOG);
    rd_chk("page_rd", IDX_PAGE, PG_ANALOG);
    chk_val("page", {24'h0, PG_ANALOG}, {24'h0, page});
    rd_chk("pos_rst", IDX_POS, 8'h00);
    rd_chk("neg_rst", IDX_NEG, 8'h00);
    // Every code in every field; D7-D6 kept alike, reserved bits zero
    for (int c = 0; c < 4; c++) begin
      setreg({2'(c), 2'(c), 2'(c), 2'h0}, {2'(c), 2'(c), 4'h0}, 8'hE0);
    end
    // Random routing and bypass use, ties seen with and without users
    for (int i = 0; i < 24; i++) begin
      byp_mic  <= 1'($urandom);
      byp_auxiliary_input_one <= 1'($urandom);
      @(posedge clk);
      p = 8'($urandom) & POS_WMASK;
      n = {p[7:6], 2'($urandom), 4'h0};
      t = {3'($urandom), 5'h00};
      setreg(p, n, t);
    end
    // Gains status drops on a routing change and returns after settling
    // Only the auxiliary_input_one field flips, so both D7-D6 fields stay alike
    xfer(1'b1, IDX_POS, p ^ 8'h10);
    @(posedge clk);
    xfer(1'b0, IDX_TERM, 8'h00);
    chk_val("done0", 32'h0000_0000, {31'h0, rd[0]});
    repeat (SC + 2) @(posedge clk);
    xfer(1'b0, IDX_TERM, 8'h00);
    chk_val("done1", 32'h0000_0001, {31'h0, rd[0]});
    // Reserved places read zero and take only their reset contents
    rd_chk("rsv51", 8'h33, 8'h00);
    xfer(1'b1, IDX_PAGE, PG_TOUCH);
    xfer(1'b1, IDX_TRSV, 8'h00);
    rd_chk("trsv", IDX_TRSV, 8'h00);
    rd_chk("pos_pg3", IDX_POS, 8'h00);
    xfer(1'b1, IDX_PAGE, 8'hFF);
    rd_chk("page_ff", IDX_PAGE, 8'hFF);
    conclude();
  end
endmodule
`default_nettype wire
